/* File: verilog/fevif_flags.sv */
// Sticky event flags, interrupt enables and host interrupt output.
// Assumes a synchronous register port and event inputs synchronous to clk.
`default_nettype none

// Contract
// RQ1: Output short sets sticky flag bit 4
// RQ2: Overheat sets flag bit 3
// RQ3: Overvoltage sets flag bit 2
// RQ4: Second comparator change sets flag bit 1
// RQ5: Main comparator change sets flag bit 0
// RQ6: Only enabled comparators set their flags
// RQ7: Writing one clears a flag
// RQ8: Writing zero or reading leaves flags alone
// RQ9: Bit 4 enable gates output-fault interrupt
// RQ10: Output-fault flag sets even when disabled
// RQ11: Bit 3 enable gates overheat interrupt
// RQ12: Overheat flag sets even when disabled
// RQ13: Bit 2 enable gates overvoltage interrupt
// RQ14: Overvoltage flag sets even when disabled
// RQ15: Bit 1 enable gates second-light interrupt
// RQ16: Second-light flag sets even when disabled
// RQ17: Bit 0 enable gates main-light interrupt
// RQ18: Main-light flag sets even when disabled
// RQ19: Pulse option drops interrupt 50 us after clear
// RQ20: Interrupt while any flag-enable pair set
// RQ21: Bits 7 to 5 read zero, ignore writes
module fevif_flags
    import fevif_pkg::*;
#(
    parameter int GAP_CYCLES = FEVIF_PULSE_GAP_CYC
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // Register port
    input  wire fevif_regreq_t regReq,
    output logic [7:0]         regRdata,
    output logic               regRvalid,
    // Event detectors
    input  wire logic          outputFaultEvent,
    input  wire logic          overheatEvent,
    input  wire logic          overvoltageEvent,
    input  wire logic          mainLightSensorInput,
    input  wire logic          secondLightSensorInput,
    input  wire logic          mainLightCmpEnable,
    input  wire logic          secondLightCmpEnable,
    // Interrupt configuration
    input  wire logic          irqPulseMode,
    // Host interrupt and flag view
    output logic               hostIrq,
    output fevif_events_t      eventFlags
);

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [4:0] status_r;
    logic [4:0] status_nxt;
    logic [4:0] enable_r;
    logic [4:0] eventSet;
    logic [4:0] clearMask;
    logic [1:0] lightChanged;
    logic       statusWrite;
    logic       enableWrite;
    logic       clearPulse;
    logic       gapBusy;
    logic       pending;

    assign statusWrite = regReq.wrEn && (regReq.addr == FEVIF_ADDR_STATUS);
    assign enableWrite = regReq.wrEn && (regReq.addr == FEVIF_ADDR_ENABLE);

    // ---------------------------------------------------------------
    // Comparator change detection
    // ---------------------------------------------------------------
    fevif_edge_detect #(
        .WIDTH (2)
    ) u_light_edge (
        .clk     (clk),
        .srst    (srst),
        .level   ({secondLightSensorInput, mainLightSensorInput}),
        .enable  ({secondLightCmpEnable, mainLightCmpEnable}),
        .changed (lightChanged)
    );

    // ---------------------------------------------------------------
    // Event set and write-one-to-clear
    // ---------------------------------------------------------------
    always_comb begin
        eventSet = '0;
        eventSet[FEVIF_BIT_OUTPUT_FAULT] = outputFaultEvent; // RQ1
        eventSet[FEVIF_BIT_OVERHEAT]     = overheatEvent; // RQ2
        eventSet[FEVIF_BIT_OVERVOLTAGE]  = overvoltageEvent; // RQ3
        eventSet[FEVIF_BIT_SECOND_LIGHT] = lightChanged[1]; // RQ4
        eventSet[FEVIF_BIT_MAIN_LIGHT]   = lightChanged[0]; // RQ5
    end

    // Only bits written as one clear; upper bits are dropped
    assign clearMask = statusWrite ? regReq.wdata[4:0] : 5'h00; // RQ7

    // Set wins over a clear in the same cycle; interrupt enables never gate the set
    assign status_nxt = (status_r & ~clearMask) | eventSet; // RQ8

    always_ff @(posedge clk) begin
        if (srst) begin
            status_r <= FEVIF_STATUS_RESET;
        end else begin
            status_r <= status_nxt; // RQ10 RQ12 RQ14 RQ16 RQ18
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_r <= FEVIF_ENABLE_RESET;
        end else if (enableWrite) begin
            enable_r <= regReq.wdata[4:0]; // RQ21
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdata  <= FEVIF_RDATA_RESET;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regReq.rdEn;
            case (regReq.addr)
                FEVIF_ADDR_STATUS: regRdata <= {3'b000, status_r}; // RQ21
                FEVIF_ADDR_ENABLE: regRdata <= {3'b000, enable_r};
                default:           regRdata <= FEVIF_RDATA_RESET;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Interrupt
    // ---------------------------------------------------------------
    assign pending    = |(status_nxt & enable_r); // RQ20 RQ9 RQ11 RQ13 RQ15 RQ17
    assign clearPulse = statusWrite && irqPulseMode && (regReq.wdata[4:0] != 5'h00 & status_r != 5'h00);

    fevif_gap_timer #(
        .GAP_CYCLES (GAP_CYCLES)
    ) u_gap (
        .clk   (clk),
        .srst  (srst),
        .start (clearPulse),
        .busy  (gapBusy)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            hostIrq <= 1'b0;
        end else begin
            hostIrq <= pending && !(irqPulseMode && (gapBusy || clearPulse)); // RQ19
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            eventFlags <= '0;
        end else begin
            eventFlags <= fevif_events_t'(status_nxt);
        end
    end

endmodule : fevif_flags

`default_nettype wire

/* File: verilog/fevif_pkg.sv */
// Package for the fault and event interrupt flag block.
// Assumes a single 40 MHz clock and an 8-bit register port.
`default_nettype none

package fevif_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] FEVIF_ADDR_STATUS = 8'h02;
    localparam logic [7:0] FEVIF_ADDR_ENABLE = 8'h03;
    localparam int         FEVIF_NUM_EVENTS  = 5;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int FEVIF_BIT_OUTPUT_FAULT = 4;
    localparam int FEVIF_BIT_OVERHEAT     = 3;
    localparam int FEVIF_BIT_OVERVOLTAGE  = 2;
    localparam int FEVIF_BIT_SECOND_LIGHT = 1;
    localparam int FEVIF_BIT_MAIN_LIGHT   = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [4:0] FEVIF_STATUS_RESET = 5'h00;
    localparam logic [4:0] FEVIF_ENABLE_RESET = 5'h00;
    localparam logic [7:0] FEVIF_RDATA_RESET  = 8'h00;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int FEVIF_CLK_HZ         = 40_000_000;
    localparam int FEVIF_PULSE_GAP_NS   = 50_000;
    localparam int FEVIF_PULSE_GAP_CYC  = (FEVIF_PULSE_GAP_NS / 1000) * (FEVIF_CLK_HZ / 1_000_000);
    localparam int FEVIF_GAP_CNT_W      = 12;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fevif_regreq_t;

    typedef struct packed {
        logic outputFault;
        logic overheat;
        logic overvoltage;
        logic secondLight;
        logic mainLight;
    } fevif_events_t;

endpackage : fevif_pkg

`default_nettype wire

/* File: verilog/fevif_edge_detect.sv */
// Per-bit change detector for the light comparator outputs.
// Assumes the comparator levels are synchronous to clk.
`default_nettype none

module fevif_edge_detect
    import fevif_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Levels in, qualified change pulses out
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] enable,
    output logic      [WIDTH-1:0] changed
);

    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] armed_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // A disabled comparator re-arms on the level it sees, so enabling it
            // does not report a stale change.
            always_ff @(posedge clk) begin
                if (srst) begin
                    prev_r[i]  <= 1'b0;
                    armed_r[i] <= 1'b0;
                end else begin
                    prev_r[i]  <= level[i];
                    armed_r[i] <= enable[i];
                end
            end
            assign changed[i] = enable[i] && armed_r[i] && (level[i] != prev_r[i]); // RQ6
        end
    endgenerate

endmodule : fevif_edge_detect

`default_nettype wire

/* File: verilog/fevif_gap_timer.sv */
// Down counter that holds the interrupt low after a flag clear.
// Assumes start is a one-cycle pulse.
`default_nettype none

module fevif_gap_timer
    import fevif_pkg::*;
#(
    parameter int GAP_CYCLES = FEVIF_PULSE_GAP_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control
    input  wire logic start,
    output logic      busy
);

    logic [FEVIF_GAP_CNT_W-1:0] count_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            count_r <= '0;
        end else if (start) begin
            count_r <= FEVIF_GAP_CNT_W'(GAP_CYCLES);
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign busy = (count_r != '0);

endmodule : fevif_gap_timer

`default_nettype wire

/* File: verif/fevif_flags_monitor.sv */
// Checker for the fault and event flag block.
// Bound to fevif_flags; sees only its ports.
`default_nettype none

module fevif_flags_monitor
    import fevif_pkg::*;
#(
    parameter int GAP_CYCLES = FEVIF_PULSE_GAP_CYC
) (
    // Clock, reset and register port
    input wire logic          clk,
    input wire logic          srst,
    input wire fevif_regreq_t regReq,
    input wire logic [7:0]    regRdata,
    input wire logic          regRvalid,
    // Events and interrupt
    input wire logic          outputFaultEvent,
    input wire logic          overheatEvent,
    input wire logic          overvoltageEvent,
    input wire logic          mainLightSensorInput,
    input wire logic          secondLightSensorInput,
    input wire logic          mainLightCmpEnable,
    input wire logic          secondLightCmpEnable,
    input wire logic          irqPulseMode,
    input wire logic          hostIrq,
    input wire fevif_events_t eventFlags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic stWr;
    assign stWr = regReq.wrEn && regReq.addr == FEVIF_ADDR_STATUS;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    fault_set_a: assert property (outputFaultEvent |=> eventFlags.outputFault) else $error("fault flag missing");
    heat_set_a: assert property (overheatEvent |=> eventFlags.overheat) else $error("heat flag missing");
    volt_set_a: assert property (overvoltageEvent |=> eventFlags.overvoltage) else $error("volt flag missing");
    fault_hold_a: assert property (eventFlags.outputFault && !(stWr && regReq.wdata[4])
        |=> eventFlags.outputFault) else $error("fault flag lost");
    fault_clear_a: assert property (stWr && regReq.wdata[4] && !outputFaultEvent
        |=> !eventFlags.outputFault) else $error("fault flag kept");
    irq_cause_a: assert property (hostIrq |-> eventFlags != 5'h00) else $error("irq without flag");
    reserved_zero_a: assert property (regRvalid |-> regRdata[7:5] == 3'h0) else $error("reserved bits set");
    read_reply_a: assert property (1'h1 |=> regRvalid == $past(regReq.rdEn)) else $error("read valid wrong");
    gap_low_a: assert property (irqPulseMode && hostIrq && stWr && regReq.wdata[4:0] != 5'h00
        |=> ##1 !hostIrq [*8]) else $error("irq not dropped");
    light_off_a: assert property ((!mainLightCmpEnable && !eventFlags.mainLight) [*2]
        |=> !eventFlags.mainLight) else $error("disabled light set");
    second_off_a: assert property ((!secondLightCmpEnable && !eventFlags.secondLight) [*2]
        |=> !eventFlags.secondLight) else $error("disabled second light set");
    cover property (stWr && regReq.wdata[4] && eventFlags.outputFault);
    cover property (irqPulseMode && hostIrq && stWr);
    cover property ($rose(eventFlags.mainLight));
endmodule : fevif_flags_monitor

bind fevif_flags fevif_flags_monitor #(.GAP_CYCLES(GAP_CYCLES)) mon_u (.*);

`default_nettype wire

/* File: verif/fevif_host_model.sv */
// Host model that issues register writes and reads.
// Assumes the register port of fevif_flags on the same clock.
`default_nettype none

module fevif_host_model
    import fevif_pkg::*;
(
    // Clock and register port
    input  wire logic          clk,
    output var fevif_regreq_t  regReq,
    input  wire logic [7:0]    regRdata,
    input  wire logic          regRvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial regReq = '{1'h0, 1'h0, 8'hFF, 8'hFF};
    // Idle bus shows the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) regReq <= '{1'h1, 1'h0, a, d};
        @(posedge clk) regReq <= '{1'h0, 1'h0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk) regReq <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge clk) regReq <= '{1'h0, 1'h0, ~a, 8'hFF};
        #1 v = regRvalid;
        d = regRdata;
    endtask : rd
endmodule : fevif_host_model

`default_nettype wire

/* File: verif/tb_fault_event_interrupt_flags.sv */
// Testbench for the fault and event flag block.
// Assumes fevif_host_model drives the register port.
`default_nettype none

module tb_fault_event_interrupt_flags
    import fevif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 10;
    logic clk, srst, regRvalid, hostIrq, outputFaultEvent, overheatEvent, overvoltageEvent;
    logic mainLightSensorInput, secondLightSensorInput, mainLightCmpEnable, secondLightCmpEnable, irqPulseMode;
    logic [7:0] regRdata;
    fevif_regreq_t regReq;
    fevif_events_t eventFlags;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    fevif_flags #(.GAP_CYCLES(GAP)) dut_u (.*);
    fevif_host_model host_u (.*);
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end
    // ----------------------------------------------------------------
    // Helpers and scenarios
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host_u.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask : rchk
    task automatic t_flags();
        logic [7:0] exp;
        exp = 8'h00;
        rchk(8'h05, 8'h00);
        rchk(FEVIF_ADDR_ENABLE, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) {outputFaultEvent, overheatEvent, overvoltageEvent} <= 3'h4 >> i;
            @(posedge clk) {outputFaultEvent, overheatEvent, overvoltageEvent} <= 3'h0;
            exp = exp | (8'h10 >> i);
            rchk(FEVIF_ADDR_STATUS, exp);
        end
        chk({7'h00, hostIrq}, 8'h00);
        host_u.wr(FEVIF_ADDR_ENABLE, 8'hFF);
        rchk(FEVIF_ADDR_ENABLE, 8'h1F);
        chk({7'h00, hostIrq}, 8'h01);
        host_u.wr(FEVIF_ADDR_STATUS, 8'h00);
        rchk(FEVIF_ADDR_STATUS, 8'h1C);
        host_u.wr(FEVIF_ADDR_STATUS, 8'h10);
        rchk(FEVIF_ADDR_STATUS, 8'h0C);
        host_u.wr(FEVIF_ADDR_STATUS, 8'hEC);
        rchk(FEVIF_ADDR_STATUS, 8'h00);
        chk({7'h00, hostIrq}, 8'h00);
        $display("test flags done");
    endtask : t_flags
    task automatic t_light();
        host_u.wr(FEVIF_ADDR_ENABLE, 8'h02);
        @(posedge clk) secondLightSensorInput <= 1'h1;
        rchk(FEVIF_ADDR_STATUS, 8'h00);
        @(posedge clk) mainLightSensorInput <= 1'h1;
        rchk(FEVIF_ADDR_STATUS, 8'h01);
        chk({7'h00, hostIrq}, 8'h00);
        @(posedge clk) secondLightCmpEnable <= 1'h1;
        repeat (3) @(posedge clk);
        secondLightSensorInput <= 1'h0;
        rchk(FEVIF_ADDR_STATUS, 8'h03);
        chk({7'h00, hostIrq}, 8'h01);
        host_u.wr(FEVIF_ADDR_STATUS, 8'h03);
        @(posedge clk) mainLightCmpEnable <= 1'h0;
        @(posedge clk) mainLightSensorInput <= 1'h0;
        rchk(FEVIF_ADDR_STATUS, 8'h00);
        $display("test light done");
    endtask : t_light
    task automatic t_pulse();
        @(posedge clk) irqPulseMode <= 1'h1;
        host_u.wr(FEVIF_ADDR_ENABLE, 8'h1F);
        @(posedge clk) {overheatEvent, overvoltageEvent} <= 2'h3;
        @(posedge clk) {overheatEvent, overvoltageEvent} <= 2'h0;
        host_u.wr(FEVIF_ADDR_STATUS, 8'h08);
        repeat (3) @(posedge clk);
        #1 chk({7'h00, hostIrq}, 8'h00);
        repeat (GAP + 5) @(posedge clk);
        #1 chk({7'h00, hostIrq}, 8'h01);
        rchk(FEVIF_ADDR_STATUS, 8'h04);
        $display("test pulse done");
    endtask : t_pulse
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial begin
        srst = 1'h1;
        {outputFaultEvent, overheatEvent, overvoltageEvent, irqPulseMode} = 4'h0;
        {mainLightSensorInput, secondLightSensorInput, secondLightCmpEnable} = 3'h0;
        mainLightCmpEnable = 1'h1;
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        t_flags();
        t_light();
        t_pulse();
        conclude();
    end
endmodule : tb_fault_event_interrupt_flags

`default_nettype wire
